// ===== bench/qwr_i2c_master.sv
/*
 * Two-wire bus master model: makes the serial clock and pulls the
 * data line low or releases it. Assumes the bench resolves the line
 * with a pull-up from both parties' pulls.
 */
`timescale 1ns/1ns
module qwr_i2c_master
(
  // Bus pins
  output logic      o_scl,
  output logic      o_sda_low,
  input  wire logic i_sda
);
  // ----------------------------------------------------------------
  // Bit and frame tasks
  // ----------------------------------------------------------------
  // Clock stands high outside frames
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // Data moves well inside the low phase, to cover the sync delay
  task automatic bitx(input logic b, output logic r);
    #50 o_sda_low = !b;
    #150 o_scl = 1'b1;
    #150 r = i_sda;
    #50 o_scl = 1'b0;
  endtask

  task automatic start();
    #100 o_sda_low = 1'b0;
    #100 o_scl = 1'b1;
    #200 o_sda_low = 1'b1;
    #200 o_scl = 1'b0;
  endtask

  task automatic stop();
    #100 o_sda_low = 1'b1;
    #100 o_scl = 1'b1;
    #200 o_sda_low = 1'b0;
    #200;
  endtask

  task automatic tx(input logic [7:0] d, output logic nk);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, nk);
  endtask

  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, d[i]);
    bitx(last, r);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] a,
                    input logic [31:0] d, input int n, output logic nk);
    logic k;
    start();
    tx({dev, 1'b0}, nk);
    tx(a, k);
    nk |= k;
    for (int i = 0; i < n; i++)
    begin
      tx(d[31 - 8 * i -: 8], k);
      nk |= k;
    end
    stop();
  endtask

  task automatic rd(input logic [6:0] dev, input logic [7:0] a, input int n,
                    output logic [31:0] q, output logic nk);
    logic       k;
    logic [7:0] b;
    q = 32'h0;
    start();
    tx({dev, 1'b0}, nk);
    tx(a, k);
    nk |= k;
    start();
    tx({dev, 1'b1}, k);
    nk |= k;
    for (int i = 0; i < n; i++)
    begin
      rx(i == n - 1, b);
      q = {q[23:0], b};
    end
    stop();
  endtask
endmodule

// ===== bench/qwr_reg_bank_i2c_test.sv
/*
 * Self-checking bench of the quad wiper register bank.
 * Assumes the master model on the bus and a pull-up on the data line.
 */
`timescale 1ns/1ns
module qwr_reg_bank_i2c_test
  import qwr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL = 3'h5;
  localparam logic [6:0] DEV = {ID_PREFIX, SEL};
  logic            clk;
  logic            rst_n;
  logic            scl;
  logic            sda_low;
  logic            sply;
  logic [2:0]      sel;
  logic            oe;
  logic            out;
  logic            shd_n;
  logic [3:0][7:0] tap;
  logic [3:0]      eopen;
  logic [3:0]      wlow;
  logic [31:0]     q;
  logic            nk;
  wire logic       sda;
  int              failures;
  int              check_count;
  int              cyc;

  qwr_i2c_master u_qwr_i2c_master (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
  qwr_reg_bank_i2c #(.SETTLE_CYCLES(2)) u_qwr_reg_bank_i2c (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(out),
    .o_sda_oe(oe), .i_addr_sel(sel), .i_supply_low(sply), .o_tap_sel(tap),
    .o_end_open(eopen), .o_wiper_to_low(wlow), .o_shutdown_n(shd_n));
  // Released line reads high through the pull-up
  assign sda = !(sda_low || (oe && !out));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Ceiling well above the roughly 7200 cycles the tests take
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Master timing starts just after a core edge, never on one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
    @(posedge clk) #2;
    u_qwr_i2c_master.wr(DEV, a, d, n, nk);
    chk("write ack", nk, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input int n, input logic [31:0] e);
    @(posedge clk) #2;
    u_qwr_i2c_master.rd(DEV, a, n, q, nk);
    chk("read ack", nk, 1'b0);
    chk("read data", q, e);
  endtask

  task automatic drop();
    repeat (8) @(posedge clk) #2 sply = 1'b1;
    @(posedge clk) #2 sply = 1'b0;
    repeat (4) @(posedge clk) #2;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("tap", tap, 32'h80808080);
    chk("shutdown_n", shd_n, 1'b1);
    chk("end open", {eopen, wlow}, 8'h00);
    chk("sda out", out, 1'b0);
    chk("sda oe", oe, 1'b0);
    rd(8'h00, 4, 32'h80808080);
    rd(CTRL_ADDR, 1, 32'h40);
    $display("test reset done");
  endtask

  task automatic t_write();
    wr(8'h00, 32'h00ff37c8, 4);
    chk("tap", tap, 32'hc837ff00);
    rd(8'h00, 4, 32'h00ff37c8);
    $display("test write done");
  endtask

  task automatic t_bad_id();
    @(posedge clk) #2;
    u_qwr_i2c_master.wr({ID_PREFIX, 3'h2}, 8'h00, 32'h11000000, 1, nk);
    chk("foreign ack", nk, 1'b1);
    // Straps moved to the foreign value: now that id must be answered
    @(posedge clk) #2 sel = 3'h2;
    u_qwr_i2c_master.wr({ID_PREFIX, 3'h2}, 8'h01, 32'hff000000, 1, nk);
    chk("strap ack", nk, 1'b0);
    @(posedge clk) #2 sel = SEL;
    u_qwr_i2c_master.wr({4'h2, SEL}, 8'h00, 32'h11000000, 1, nk);
    chk("prefix ack", nk, 1'b1);
    rd(8'h00, 1, 32'h00);
    $display("test bad id done");
  endtask

  task automatic t_ctrl();
    wr(CTRL_ADDR, 32'hff000000, 1);
    rd(CTRL_ADDR, 1, 32'h40);
    drop();
    chk("tap", tap, 32'hc837ff00);
    wr(CTRL_ADDR, 32'hbf000000, 1);
    chk("shutdown_n", shd_n, 1'b0);
    chk("end open", {eopen, wlow}, 8'hff);
    rd(CTRL_ADDR, 1, 32'h00);
    rd(8'h00, 4, 32'h00ff37c8);
    wr(CTRL_ADDR, 32'h40000000, 1);
    chk("end open", {eopen, wlow}, 8'h00);
    chk("tap", tap, 32'hc837ff00);
    wr(CTRL_ADDR, 32'h00000000, 1);
    drop();
    chk("tap", tap, 32'h80808080);
    wr(CTRL_ADDR, 32'h40000000, 1);
    rd(8'h00, 4, 32'h80808080);
    $display("test control done");
  endtask

  task automatic t_unmapped();
    wr(8'h05, 32'h5a000000, 1);
    rd(8'h05, 1, 32'h00);
    wr(8'h03, 32'h11220000, 2);
    rd(8'h03, 2, 32'h00001100);
    chk("tap", tap, 32'h11808080);
    $display("test unmapped done");
  endtask

  initial
  begin
    rst_n = 1'b0;
    sply = 1'b0;
    sel = SEL;
    failures = 0;
    check_count = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge clk) #2;
    t_reset();
    t_write();
    t_bad_id();
    t_ctrl();
    t_unmapped();
    summarize();
  end
endmodule

// ===== verilog/qwr_pin_if.sv
/*
 * Carrier for synchronised serial bus pin events between the pin
 * synchroniser and the register bank core.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ns
interface qwr_pin_if;
  logic       scl_rise;
  logic       scl_fall;
  logic       sda_in;
  logic       start;
  logic       stop;
  logic       supply_low;
  logic [2:0] addr_sel;

  modport prod (output scl_rise, scl_fall, sda_in, start, stop, supply_low, addr_sel);
  modport cons (input  scl_rise, scl_fall, sda_in, start, stop, supply_low, addr_sel);
endinterface

// ===== verilog/qwr_pin_sync.sv
/*
 * Two-flop synchronisers for the serial bus pins, the address select
 * straps and the supply dropout level, plus edge, start and stop
 * detection on the synchronised copies.
 * Assumes the serial clock is far slower than the core clock.
 */
`timescale 1ns/1ns
module qwr_pin_sync
  import qwr_pkg::*;
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  // Raw pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [2:0] i_addr_sel,
  input  wire logic       i_supply_low,
  // Events to the core
  qwr_pin_if.prod         pin
);

  // ----------------------------------------------------------------
  // State: first stage, second stage, one delayed copy of scl/sda
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] meta;
    logic [5:0] sync;
    logic       scl_d;
    logic       sda_d;
  } qwr_sync_s;

  qwr_sync_s st;
  qwr_sync_s next_st;

  always_comb
  begin
    next_st       = st;
    next_st.meta  = {i_scl, i_sda, i_addr_sel, i_supply_low};
    next_st.sync  = st.meta;
    next_st.scl_d = st.sync[5];
    next_st.sda_d = st.sync[4];
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st <= '{meta: 6'h30, sync: 6'h30, scl_d: 1'b1, sda_d: 1'b1};
    else
      st <= next_st;
  end

  // Data sampled on the rising serial clock, driven after the falling
  assign pin.scl_rise   = st.sync[5] & ~st.scl_d;
  assign pin.scl_fall   = ~st.sync[5] & st.scl_d;
  assign pin.sda_in     = st.sync[4];
  assign pin.start      = st.sync[5] & st.scl_d & st.sda_d & ~st.sync[4];
  assign pin.stop       = st.sync[5] & st.scl_d & ~st.sda_d & st.sync[4];
  assign pin.addr_sel   = st.sync[3:1];
  assign pin.supply_low = st.sync[0];

endmodule

// ===== verilog/qwr_pkg.sv
/*
 * Shared constants of the quad wiper register bank: register map,
 * reset presets, identification byte layout and timing counts.
 * Assumes a 20 MHz core clock for every cycle count derived here.
 */
package qwr_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         NUM_CH          = 4;
  localparam logic [7:0] WIPER_ADDR_LAST = 8'h03;
  localparam logic [7:0] CTRL_ADDR       = 8'h10;
  localparam logic [7:0] WIPER_RESET     = 8'h80;
  localparam logic [7:0] CTRL_RESET      = 8'h40;
  localparam int         SHUTDOWN_N_BIT        = 6;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // ----------------------------------------------------------------
  // Identification byte: fixed prefix, three select bits, direction
  // ----------------------------------------------------------------
  localparam logic [3:0] ID_PREFIX  = 4'ha;
  localparam logic       DIR_READ   = 1'b1;
  localparam logic [3:0] BITS_FRAME = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DROP_NS     = 200;
  localparam int DROP_CYC    = (DROP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_NS   = 1000;
  localparam int SETTLE_CYC  = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== verilog/qwr_reg_bank_i2c.sv
/*
 * Quad wiper register bank behind a two-wire serial slave port.
 * Holds four wiper position registers and the power down control
 * register, answers identification, address, write and read bytes.
 * Assumes an external pull-up on the data line and a bus master that
 * drives the serial clock far slower than the 20 MHz core clock.
 */
// Contract
// - Four 8-bit wiper registers and one 8-bit control register.
// - Wiper register of channel i sits at address i, 0 to 3.
// - Control register at address 10h, value 40h after power-up.
// - Code 00h selects the tap nearest the low terminal.
// - Code FFh selects the tap nearest the high terminal.
// - Tap moves monotonically, one tap per code step.
// - Power-up loads every wiper register with 80h, the centre tap.
// - Control bit 6 is active-low shutdown for all channels, rest zero.
// - In shutdown each array opens and wiper joins low terminal.
// - Shutdown bit reads 1 after power-up, normal operation.
// - Entering shutdown leaves wiper registers unchanged.
// - Leaving shutdown returns wipers to stored taps after settling.
// - Supply dropout during shutdown reloads all wipers to mid-scale.
// - Device is slave only; master starts transfers and clocks bus.
// - Every byte travels most significant bit first.
// - Sample data on rising serial clock, change after falling edge.
// - Data line driven open-drain only: pull low or release.
// - Three select inputs give low address bits; respond only on match.
// - Wiper registers are readable and writable over the serial bus.
// - Identification byte: 1010, three select bits, direction bit.
// - Write: id, address, data, each acknowledged; commit on ninth clock.
// - Further data bytes write consecutive channels in one transfer.
// - Read: write id, address, repeated start, read id, data, NACK, stop.
`timescale 1ns/1ns
module qwr_reg_bank_i2c
  import qwr_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
)
(
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  // Serial bus
  input  wire logic             i_scl,
  input  wire logic             i_sda,
  output logic                  o_sda_out,
  output logic                  o_sda_oe,
  // Straps and supply monitor
  input  wire logic [2:0]       i_addr_sel,
  input  wire logic             i_supply_low,
  // Potentiometer channels
  output logic      [3:0][7:0]  o_tap_sel,
  output logic      [3:0]       o_end_open,
  output logic      [3:0]       o_wiper_to_low,
  output logic                  o_shutdown_n
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_ID, S_IDACK, S_ADDR, S_ADDRACK, S_WDATA, S_WACK, S_RDATA, S_RACK
  } qwr_state_e;

  typedef struct packed {
    qwr_state_e      state;
    logic [3:0]      cnt;
    logic [7:0]      shift;
    logic [7:0]      ptr;
    logic            rw;
    logic            mack;
    logic            sda_low;
    logic [3:0][7:0] wiper_position;
    logic            shutdown_n;
  } qwr_core_s;

  localparam qwr_core_s CORE_RESET = '{
    state:          S_IDLE,
    cnt:            4'h0,
    shift:          8'h00,
    ptr:            8'h00,
    rw:             1'b0,
    mack:           1'b0,
    sda_low:        1'b0,
    wiper_position: {4{WIPER_RESET}},
    shutdown_n:     CTRL_RESET[SHUTDOWN_N_BIT]
  };

  qwr_core_s st;
  qwr_core_s next_st;
  logic      reload;
  logic      id_match;
  logic [7:0] rd_now;
  logic [7:0] rd_next;

  qwr_pin_if pin ();

  // ----------------------------------------------------------------
  // Pin synchronisers and tap stage
  // ----------------------------------------------------------------
  qwr_pin_sync u_sync (
    .i_core_clk   (i_core_clk),
    .i_rst_n      (i_rst_n),
    .i_scl        (i_scl),
    .i_sda        (i_sda),
    .i_addr_sel   (i_addr_sel),
    .i_supply_low (i_supply_low),
    .pin          (pin.prod)
  );

  qwr_wiper_out #(
    .SETTLE_CYCLES (SETTLE_CYCLES),
    .DROP_CYCLES   (DROP_CYC)
  ) u_out (
    .i_core_clk     (i_core_clk),
    .i_rst_n        (i_rst_n),
    .i_wiper        (st.wiper_position),
    .i_shutdown_n   (st.shutdown_n),
    .i_supply_low   (pin.supply_low),
    .o_tap_sel      (o_tap_sel),
    .o_end_open     (o_end_open),
    .o_wiper_to_low (o_wiper_to_low),
    .o_reload       (reload)
  );

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                          input logic [3:0][7:0] wp,
                                          input logic shutdown_n_n);
    logic [7:0] val;
    val = READ_UNMAPPED;
    if (addr <= WIPER_ADDR_LAST)
      val = wp[addr[1:0]];
    else if (addr == CTRL_ADDR)
    begin
      val           = 8'h00;
      val[SHUTDOWN_N_BIT] = shutdown_n_n;
    end
    return val;
  endfunction

  assign rd_now   = read_reg(st.ptr, st.wiper_position, st.shutdown_n);
  assign rd_next  = read_reg(st.ptr + 8'h01, st.wiper_position, st.shutdown_n);
  assign id_match = (st.shift[7:1] == {ID_PREFIX, pin.addr_sel});

  // ----------------------------------------------------------------
  // Serial slave sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    unique case (st.state)
      S_IDLE:
      begin
        // Slave only: nothing happens until the master sends a start
        next_st.sda_low = 1'b0;
      end
      S_ID, S_ADDR, S_WDATA:
      begin
        if (pin.scl_rise && st.cnt != BITS_FRAME)
        begin
          next_st.shift = {st.shift[6:0], pin.sda_in};
          next_st.cnt   = st.cnt + 4'h1;
        end
        if (pin.scl_fall && st.cnt == BITS_FRAME)
        begin
          next_st.cnt     = 4'h0;
          next_st.sda_low = 1'b1;
          if (st.state == S_ID)
          begin
            next_st.rw    = st.shift[0];
            next_st.state = S_IDACK;
            if (!id_match)
            begin
              // Another device on the bus: stay silent until next start
              next_st.sda_low = 1'b0;
              next_st.state   = S_IDLE;
            end
          end
          else if (st.state == S_ADDR)
          begin
            next_st.ptr   = st.shift;
            next_st.state = S_ADDRACK;
          end
          else
            next_st.state = S_WACK;
        end
      end
      S_IDACK:
      begin
        if (pin.scl_fall)
        begin
          next_st.sda_low = 1'b0;
          next_st.state   = S_ADDR;
          if (st.rw == DIR_READ)
          begin
            next_st.shift   = rd_now;
            next_st.sda_low = ~rd_now[7];
            next_st.state   = S_RDATA;
          end
        end
      end
      S_ADDRACK:
      begin
        if (pin.scl_fall)
        begin
          next_st.sda_low = 1'b0;
          next_st.state   = S_WDATA;
        end
      end
      S_WACK:
      begin
        // Commit on the rising edge of the ninth clock
        if (pin.scl_rise)
        begin
          if (st.ptr <= WIPER_ADDR_LAST)
            next_st.wiper_position[st.ptr[1:0]] = st.shift;
          else if (st.ptr == CTRL_ADDR)
            next_st.shutdown_n = st.shift[SHUTDOWN_N_BIT];
          next_st.ptr = st.ptr + 8'h01;
        end
        if (pin.scl_fall)
        begin
          next_st.sda_low = 1'b0;
          next_st.state   = S_WDATA;
        end
      end
      S_RDATA:
      begin
        if (pin.scl_rise)
          next_st.cnt = st.cnt + 4'h1;
        if (pin.scl_fall)
        begin
          if (st.cnt == BITS_FRAME)
          begin
            next_st.cnt     = 4'h0;
            next_st.sda_low = 1'b0;
            next_st.state   = S_RACK;
          end
          else
          begin
            next_st.shift   = {st.shift[6:0], 1'b0};
            next_st.sda_low = ~st.shift[6];
          end
        end
      end
      S_RACK:
      begin
        if (pin.scl_rise)
          next_st.mack = ~pin.sda_in;
        if (pin.scl_fall)
        begin
          next_st.state = S_IDLE;
          if (st.mack)
          begin
            next_st.ptr     = st.ptr + 8'h01;
            next_st.shift   = rd_next;
            next_st.sda_low = ~rd_next[7];
            next_st.state   = S_RDATA;
          end
        end
      end
    endcase
    // Bus conditions override any byte in flight
    if (pin.stop)
    begin
      next_st.sda_low = 1'b0;
      next_st.state   = S_IDLE;
    end
    if (pin.start)
    begin
      next_st.sda_low = 1'b0;
      next_st.cnt     = 4'h0;
      next_st.state   = S_ID;
    end
    // Dropout in shutdown wins over a coincident write
    if (reload && !st.shutdown_n)
      next_st.wiper_position = {4{WIPER_RESET}};
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st <= CORE_RESET;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Never drive high; the pull-up makes the one
  assign o_sda_out    = 1'b0;
  assign o_sda_oe     = st.sda_low;
  assign o_shutdown_n = st.shutdown_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  chk_sda_open_drain: assert property (
    $rose(o_sda_oe) |-> !o_sda_out && st.state inside {S_IDACK, S_ADDRACK, S_WACK, S_RDATA})
    else $error("data line pulled outside ack or read");

  chk_sda_change_edge: assert property (
    $changed(o_sda_oe) |-> $past(pin.scl_fall || pin.start || pin.stop))
    else $error("data line moved away from falling clock");

  chk_id_mismatch_quiet: assert property (
    st.state == S_ID && pin.scl_fall && st.cnt == BITS_FRAME && !id_match && !pin.start
    |=> !o_sda_oe && st.state == S_IDLE)
    else $error("acknowledged a foreign address");

  chk_idle_released: assert property (
    st.state == S_IDLE |-> !o_sda_oe)
    else $error("data line held while idle");

  chk_wiper_write_only: assert property (
    !$stable(st.wiper_position) |->
      $past((st.state == S_WACK && pin.scl_rise && st.ptr <= WIPER_ADDR_LAST) || reload))
    else $error("wiper register changed without cause");

  chk_unmapped_no_ctrl: assert property (
    st.state == S_WACK && pin.scl_rise && st.ptr != CTRL_ADDR |=> $stable(st.shutdown_n))
    else $error("control changed by unmapped write");

  chk_shutdown_keeps: assert property (
    $fell(st.shutdown_n) |-> $stable(st.wiper_position))
    else $error("wiper changed on shutdown entry");

  chk_reload_mid: assert property (
    reload && !st.shutdown_n |=> st.wiper_position == {4{WIPER_RESET}})
    else $error("dropout reload missed");

  chk_read_msb_first: assert property (
    st.state == S_RDATA && $past(st.state) == S_RDATA |-> o_sda_oe == ~st.shift[7])
    else $error("read bit order wrong");

  cov_write_commit: cover property (st.state == S_WACK && pin.scl_rise);
  cov_read_byte:    cover property (st.state == S_RDATA ##[1:400] st.state == S_RACK);
  cov_shutdown:     cover property ($fell(st.shutdown_n));
  cov_reload:       cover property (reload && !st.shutdown_n);

endmodule

// ===== verilog/qwr_wiper_out.sv
/*
 * Tap selection stage for the four potentiometer channels: registered
 * tap codes, shutdown switching with a settling hold on exit, and the
 * supply dropout filter that asks the core for a mid-scale reload.
 * Assumes the supply dropout level is already synchronised.
 */
`timescale 1ns/1ns
module qwr_wiper_out
  import qwr_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int DROP_CYCLES   = DROP_CYC
)
(
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_n,
  // From the register bank
  input  wire logic [3:0][7:0]       i_wiper,
  input  wire logic                  i_shutdown_n,
  input  wire logic                  i_supply_low,
  // To the analog arrays and back to the core
  output logic      [3:0][7:0]       o_tap_sel,
  output logic      [3:0]            o_end_open,
  output logic      [3:0]            o_wiper_to_low,
  output logic                       o_reload
);

  // Settle counter is 16 bits, dropout counter 8 bits
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535 || DROP_CYCLES < 1 || DROP_CYCLES > 255)
  begin : g_bad_timing
    $error("qwr_wiper_out: timing count out of range");
  end

  typedef struct packed {
    logic [3:0][7:0] tap;
    logic            open;
    logic [15:0]     settle;
    logic [7:0]      drop;
    logic            reload;
  } qwr_out_s;

  qwr_out_s st;
  qwr_out_s next_st;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st        = st;
    // Tap code follows the register one for one, 00 low end, ff high end
    next_st.tap    = i_wiper;
    next_st.reload = 1'b0;
    if (!i_shutdown_n)
    begin
      next_st.open   = 1'b1;
      next_st.settle = 16'(SETTLE_CYCLES);
    end
    else if (st.settle != 16'h0000)
    begin
      // Array stays open until the switches have settled
      next_st.settle = st.settle - 16'h0001;
      next_st.open   = 1'b1;
    end
    else
      next_st.open = 1'b0;
    // Dropout must persist before it counts; short glitches are ignored
    if (!i_shutdown_n && i_supply_low)
    begin
      if (st.drop != 8'(DROP_CYCLES))
        next_st.drop = st.drop + 8'h01;
      next_st.reload = (st.drop == 8'(DROP_CYCLES - 1));
    end
    else
      next_st.drop = 8'h00;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st <= '{tap: {4{WIPER_RESET}}, open: 1'b0, settle: 16'h0000,
              drop: 8'h00, reload: 1'b0};
    else
      st <= next_st;
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      assign o_tap_sel[ch]      = st.tap[ch];
      assign o_end_open[ch]     = st.open;
      assign o_wiper_to_low[ch] = st.open;
    end
  endgenerate
  assign o_reload = st.reload;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_exit_settle_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(i_shutdown_n) |-> ##1 st.open [*2])
    else $error("array closed before settling");

  chk_tap_tracks_reg: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    ##1 st.tap == $past(i_wiper))
    else $error("tap code does not follow register");

endmodule
